// ===== src/mfa_flow_action.sv
// mfa_flow_action: per-frame flow action decode after the sa lookup
// assumes lookup result and frame framing are synchronous to i_core_clk
//
// Design decisions made here: register access over AHB-Lite and the address map.
`timescale 1ns/100ps
`default_nettype none
module mfa_flow_action #(
  parameter int unsigned P_NUM_SA = mfa_pkg::NUM_SA
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire logic i_sof,
  input wire logic i_eof,
  input wire logic i_sa_hit,
  input wire logic [mfa_pkg::IDX_W-1:0] i_sa_index,
  input wire logic i_ctrl_pkt,
  input wire logic [1:0] i_tag_class,
  input wire logic i_from_reserved,
  input wire logic [1:0] i_vlan_tags,
  output logic o_act_valid,
  output logic [1:0] o_flow_type,
  output logic [1:0] o_dest_port,
  output logic [1:0] o_drop_method,
  output logic o_drop_frame,
  output logic o_crc_corrupt,
  output logic o_pkt_error,
  output logic o_drop_internal,
  output logic o_association_active_flag,
  output logic o_protect_frame,
  output logic o_include_sci,
  output logic o_end_station_bit_enable,
  output logic o_scb_enable,
  output logic [1:0] o_tag_bypass_size,
  output logic [mfa_pkg::COFF_W-1:0] o_conf_offset,
  output logic o_conf_protect,
  output logic o_replay_protect,
  output logic [1:0] o_validate_level,
  output logic o_ctx_valid,
  output logic [mfa_pkg::IDX_W-1:0] o_ctx_index,
  output logic o_hdr_bypass,
  output logic [mfa_pkg::HDR_W-1:0] o_hdr_size,
  output logic o_ctrl_pkt,
  output logic o_direction_ingress
);
  import mfa_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // register storage; actions are arrays so one decode serves every flow
  logic [31:0] egr_act_reg [P_NUM_SA];
  logic [31:0] igr_act_reg [P_NUM_SA];
  logic [31:0] nm_act_reg [NUM_NM];
  logic [31:0] misc_reg;
  logic [31:0] frames_reg;
  logic [31:0] drops_reg;
  logic in_frame_reg;

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave: zero wait states, always okay
  logic wr_pend_reg;
  logic [ADDR_W-1:0] wr_addr_reg;
  logic [ADDR_W-1:0] rd_addr_reg;
  logic addr_ok;
  assign addr_ok = i_hsel && i_hready && i_htrans[1];

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= '0;
      rd_addr_reg <= '0;
    end else begin
      wr_pend_reg <= addr_ok && i_hwrite;
      if (addr_ok) begin
        wr_addr_reg <= i_haddr[ADDR_W-1:0];
        rd_addr_reg <= i_haddr[ADDR_W-1:0];
      end
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end else begin
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end
  end

  // full in-page word index so words past the table never alias onto it
  logic [PAGE_LSB-WORD_LSB-1:0] wr_word;
  logic [PAGE_LSB-WORD_LSB-1:0] rd_word;
  assign wr_word = wr_addr_reg[WORD_LSB +: PAGE_LSB-WORD_LSB];
  assign rd_word = i_haddr[WORD_LSB +: PAGE_LSB-WORD_LSB];

  // writes land one cycle after the address phase, with hwdata
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < P_NUM_SA; i++) begin
        egr_act_reg[i] <= ACT_RESET;
        igr_act_reg[i] <= ACT_RESET;
      end
      for (int i = 0; i < NUM_NM; i++) begin
        nm_act_reg[i] <= ACT_RESET;
      end
      misc_reg <= ACT_RESET;
    end else if (wr_pend_reg) begin
      if ((wr_addr_reg & PAGE_MASK) == EGR_BASE && wr_word < P_NUM_SA) begin
        egr_act_reg[wr_word[IDX_W-1:0]] <= i_hwdata;
      end
      if ((wr_addr_reg & PAGE_MASK) == IGR_BASE && wr_word < P_NUM_SA) begin
        igr_act_reg[wr_word[IDX_W-1:0]] <= i_hwdata;
      end
      if ((wr_addr_reg & PAGE_MASK) == NM_BASE && wr_word < NUM_NM) begin
        nm_act_reg[wr_word[2:0]] <= i_hwdata;
      end
      if (wr_addr_reg == MISC_ADDR) begin
        misc_reg <= i_hwdata;
      end
    end
  end

  // read data registered in the address phase so it stands in the data phase
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_hrdata <= '0;
    end else if (addr_ok && !i_hwrite) begin
      o_hrdata <= '0;
      if ((i_haddr[ADDR_W-1:0] & PAGE_MASK) == EGR_BASE && rd_word < P_NUM_SA) begin
        o_hrdata <= egr_act_reg[rd_word[IDX_W-1:0]];
      end
      if ((i_haddr[ADDR_W-1:0] & PAGE_MASK) == IGR_BASE && rd_word < P_NUM_SA) begin
        o_hrdata <= igr_act_reg[rd_word[IDX_W-1:0]];
      end
      if ((i_haddr[ADDR_W-1:0] & PAGE_MASK) == NM_BASE && rd_word < NUM_NM) begin
        o_hrdata <= nm_act_reg[rd_word[2:0]];
      end
      if (i_haddr[ADDR_W-1:0] == MISC_ADDR) begin
        o_hrdata <= misc_reg;
      end
      if (i_haddr[ADDR_W-1:0] == STAT_ADDR) begin
        o_hrdata <= {drops_reg[14:0], in_frame_reg, frames_reg[15:0]};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // action selection at frame start
  logic ingress;
  logic [4:0] hdr_sz;
  logic [2:0] nm_idx;
  logic [31:0] act;
  logic [1:0] ftype;
  logic drop_now;
  assign ingress = misc_reg[M_DIR] != DIR_EGR[0];
  assign hdr_sz = misc_reg[M_HSZ +: HDR_W];
  assign nm_idx = {i_ctrl_pkt, i_tag_class};

  always_comb begin
    act = nm_act_reg[nm_idx];
    ftype = act[F_TYPE +: 2];
    if (ftype == FT_PROCESS) begin
      ftype = FT_DROP;
    end
    if (i_sa_hit) begin
      act = ingress ? igr_act_reg[i_sa_index] : egr_act_reg[i_sa_index];
      ftype = act[F_TYPE +: 2];
    end
    drop_now = ftype == FT_DROP;
    if (i_sa_hit && ingress && act[I_DNR] && !i_from_reserved) begin
      drop_now = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      in_frame_reg <= 1'b0;
      frames_reg <= '0;
      drops_reg <= '0;
    end else begin
      if (i_sof) begin
        in_frame_reg <= 1'b1;
        frames_reg <= frames_reg + 32'h0000_0001;
        if (drop_now) begin
          drops_reg <= drops_reg + 32'h0000_0001;
        end
      end else if (i_eof) begin
        in_frame_reg <= 1'b0;
      end
    end
  end

  // all action outputs latched once per frame and held to its end
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_act_valid <= 1'b0;
      o_flow_type <= FT_BYPASS;
      o_dest_port <= PORT_COMMON;
      o_drop_method <= DROP_CRC;
      o_drop_frame <= 1'b0;
      o_crc_corrupt <= 1'b0;
      o_pkt_error <= 1'b0;
      o_drop_internal <= 1'b0;
      o_association_active_flag <= 1'b0;
      o_protect_frame <= 1'b0;
      o_include_sci <= 1'b0;
      o_end_station_bit_enable <= 1'b0;
      o_scb_enable <= 1'b0;
      o_tag_bypass_size <= '0;
      o_conf_offset <= '0;
      o_conf_protect <= 1'b0;
      o_replay_protect <= 1'b0;
      o_validate_level <= VAL_DISABLED;
      o_ctx_valid <= 1'b0;
      o_ctx_index <= '0;
      o_hdr_bypass <= 1'b0;
      o_hdr_size <= '0;
      o_ctrl_pkt <= 1'b0;
      o_direction_ingress <= 1'b0;
    end else if (i_sof) begin
      o_act_valid <= 1'b1;
      o_flow_type <= drop_now ? FT_DROP : ftype;
      o_dest_port <= act[F_DEST +: 2];
      o_drop_method <= act[F_DROP +: 2];
      o_drop_frame <= drop_now;
      o_crc_corrupt <= drop_now && act[F_DROP +: 2] == DROP_CRC;
      o_pkt_error <= drop_now && act[F_DROP +: 2] == DROP_PKTERR;
      o_drop_internal <= drop_now && act[F_DROP +: 2] == DROP_INTERNAL;
      o_association_active_flag <= i_sa_hit && act[F_USE];
      // bypass and drop flows leave o_protect_frame off; sci, es, scb and conf protect follow the action bits in egress and stay off in ingress
      o_protect_frame <= !ingress && !drop_now && ftype == FT_PROCESS && act[E_PROT];
      o_include_sci <= !ingress && act[E_SCI];
      o_end_station_bit_enable <= !ingress && act[E_ES];
      o_scb_enable <= !ingress && act[E_SCB];
      if (!ingress && act[E_TBS +: 2] <= TAGS_MAX) begin
        o_tag_bypass_size <= act[E_TBS +: 2];
      end else begin
        o_tag_bypass_size <= ingress && i_vlan_tags <= TAGS_MAX ? i_vlan_tags : 2'h0;
      end
      o_conf_offset <= act[F_COFF +: COFF_W];
      o_conf_protect <= !ingress && act[E_CONF];
      o_replay_protect <= ingress && act[I_RPL];
      o_validate_level <= ingress ? act[I_VAL +: 2] : VAL_DISABLED;
      o_ctx_valid <= i_sa_hit && !drop_now && ftype == FT_PROCESS;
      o_ctx_index <= i_sa_index;
      o_hdr_bypass <= hdr_sz >= HDR_MIN && hdr_sz <= HDR_MAX;
      o_hdr_size <= hdr_sz;
      o_ctrl_pkt <= i_ctrl_pkt;
      o_direction_ingress <= ingress;
    end else if (i_eof) begin
      o_act_valid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  // frame start with and without a lookup hit
  sequence sof_hit_s;
    i_sof && i_sa_hit;
  endsequence
  sequence sof_miss_s;
    i_sof && !i_sa_hit;
  endsequence
  held_in_frame_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_act_valid && !i_sof && !$past(i_sof) |-> $stable(o_dest_port) && $stable(o_flow_type))
    else $error("action changed inside a frame");
  drop_internal_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_drop_internal |-> o_drop_frame && o_drop_method == DROP_INTERNAL)
    else $error("internal drop without drop method");
  nm_no_process_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    sof_miss_s |=> o_flow_type != FT_PROCESS && !o_ctx_valid)
    else $error("unmatched frame processed");
  reserved_drop_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_sof && i_sa_hit && ingress && act[I_DNR] && !i_from_reserved |=> o_drop_frame)
    else $error("non reserved frame not dropped");
  bypass_clean_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_flow_type == FT_BYPASS |-> !o_protect_frame && !o_drop_frame && !o_ctx_valid)
    else $error("bypass frame altered");
  egr_replay_off_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_act_valid && !o_direction_ingress |-> !o_replay_protect)
    else $error("replay on in egress");
  tag_size_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_tag_bypass_size <= TAGS_MAX)
    else $error("tag bypass size out of range");
  dest_port_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_sof ##1 1'b1 |-> o_dest_port == $past(act[F_DEST +: 2]))
    else $error("dest port not taken from action");
  act_valid_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    i_sof |=> o_act_valid)
    else $error("action not valid after frame start");
  ctx_index_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    sof_hit_s |=> o_ctx_index == $past(i_sa_index))
    else $error("context index not taken from lookup");
  nm_no_assoc_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    sof_miss_s |=> !o_association_active_flag)
    else $error("association flag on unmatched frame");
  drop_kind_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_crc_corrupt || o_pkt_error |-> o_drop_frame && o_flow_type == FT_DROP)
    else $error("drop indication without drop");
  ingr_tx_off_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_act_valid && o_direction_ingress |-> !o_protect_frame && !o_include_sci && !o_conf_protect)
    else $error("egress controls on in ingress");
endmodule : mfa_flow_action
`default_nettype wire

// ===== include/mfa_pkg.sv
// mfa_pkg: register map, field layout and encodings of the flow action decoder
// assumes a single 100 MHz core clock and a word-wide ahb-lite register bus
package mfa_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned NUM_SA = 16;
  localparam int unsigned IDX_W = 4;
  localparam int unsigned NUM_NM = 8;
  // register map (byte addresses)
  localparam logic [ADDR_W-1:0] EGR_BASE = 12'h000;
  localparam logic [ADDR_W-1:0] IGR_BASE = 12'h100;
  localparam logic [ADDR_W-1:0] NM_BASE = 12'h200;
  localparam logic [ADDR_W-1:0] MISC_ADDR = 12'h300;
  localparam logic [ADDR_W-1:0] STAT_ADDR = 12'h304;
  localparam logic [ADDR_W-1:0] PAGE_MASK = 12'hF00;
  localparam int unsigned WORD_LSB = 2;
  localparam int unsigned PAGE_LSB = 8;
  // flow action fields; F_ fields shared, E_ egress-only and I_ ingress-only fields reuse the same bits
  localparam int unsigned F_TYPE = 0;
  localparam int unsigned F_DEST = 2;
  localparam int unsigned F_DROP = 6;
  localparam int unsigned F_USE = 9;
  localparam int unsigned E_PROT = 8;
  localparam int unsigned E_SCI = 10;
  localparam int unsigned E_ES = 11;
  localparam int unsigned E_SCB = 12;
  localparam int unsigned E_TBS = 13;
  localparam int unsigned F_COFF = 16;
  localparam int unsigned E_CONF = 23;
  localparam int unsigned I_DNR = 8;
  localparam int unsigned I_RPL = 10;
  localparam int unsigned I_VAL = 11;
  localparam int unsigned COFF_W = 7;
  localparam int unsigned M_HDR = 0;
  localparam int unsigned HDR_W = 5;
  localparam int unsigned M_DIR = 1;
  localparam int unsigned M_HSZ = 8;
  localparam logic [31:0] ACT_RESET = 32'h0000_0000;
  localparam logic [1:0] DIR_EGR = 2'h0;
  typedef enum logic [1:0] {FT_BYPASS = 2'h0, FT_DROP = 2'h1, FT_PROCESS = 2'h2} mfa_ftype_t;
  typedef enum logic [1:0] {PORT_COMMON = 2'h0, PORT_RESERVED = 2'h1,
                            PORT_CONTROLLED = 2'h2, PORT_UNCONTROLLED = 2'h3} mfa_port_t;
  typedef enum logic [1:0] {DROP_CRC = 2'h0, DROP_PKTERR = 2'h1, DROP_INTERNAL = 2'h2} mfa_drop_t;
  typedef enum logic [1:0] {VAL_DISABLED = 2'h0, VAL_CHECK = 2'h1, VAL_STRICT = 2'h2} mfa_val_t;
  typedef enum logic [1:0] {TAG_UNTAGGED = 2'h0, TAG_TAGGED = 2'h1, TAG_BAD = 2'h2, TAG_KAY = 2'h3} mfa_tag_t;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [4:0] HDR_MIN = 5'h02;
  localparam logic [4:0] HDR_MAX = 5'h10;
  localparam logic [1:0] TAGS_MAX = 2'h2;
endpackage : mfa_pkg

// ===== tb/mfa_frame_src.sv
// mfa_frame_src: mac-side model giving frame framing and the lookup result
// assumes one go pulse per frame, the next go only after the last cycle of a frame
`timescale 1ns/100ps
`default_nettype none
module mfa_frame_src #(
  parameter int unsigned P_LEN = 10
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_go,
  input wire logic [10:0] i_look,
  output logic o_sof,
  output logic o_eof,
  output logic [10:0] o_look
);
  int unsigned cnt;
  logic [10:0] look_reg;
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt <= 0;
      look_reg <= 11'h000;
    end else if (i_go) begin
      cnt <= P_LEN;
      look_reg <= i_look;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
  end
  assign o_sof = (cnt == P_LEN);
  assign o_eof = (cnt == 1);
  // lookup result qualified only at sof; inverted elsewhere so a stale value is never trusted
  assign o_look = o_sof ? look_reg : ~look_reg;
endmodule : mfa_frame_src
`default_nettype wire

// ===== tb/mfa_flow_action_bench.sv
// mfa_flow_action_bench: directed bench for the flow action decoder
// assumes a zero-wait register bus and one frame in flight at a time
`timescale 1ns/100ps
`default_nettype none
module mfa_flow_action_bench;
  import mfa_pkg::*;
  logic i_core_clk = 0, i_rst = 1, i_hsel = 0, i_hwrite = 0, go = 0;
  logic [31:0] i_haddr = 32'h0000_0000, i_hwdata = 32'h0000_0000, o_hrdata, rd;
  logic [1:0] i_htrans = 2'h0;
  logic [2:0] i_hsize = HSIZE_WORD;
  logic [10:0] look = 11'h000, lk;
  logic i_sof, i_eof, o_hreadyout, o_hresp, o_act_valid, o_drop_frame, o_crc_corrupt, o_pkt_error, o_drop_internal;
  logic o_association_active_flag, o_protect_frame, o_include_sci, o_end_station_bit_enable, o_scb_enable;
  logic o_conf_protect, o_replay_protect, o_ctx_valid, o_hdr_bypass, o_ctrl_pkt, o_direction_ingress;
  logic [1:0] o_flow_type, o_dest_port, o_drop_method, o_tag_bypass_size, o_validate_level;
  logic [COFF_W-1:0] o_conf_offset;
  logic [IDX_W-1:0] o_ctx_index;
  logic [HDR_W-1:0] o_hdr_size;
  int n_fail = 0, checks = 0;
  ////////////////////////////////////////////////////////////////////////////
  mfa_flow_action u_dut (.i_core_clk, .i_rst, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize, .i_hwdata,
    .i_hready(o_hreadyout), .o_hrdata, .o_hreadyout, .o_hresp, .i_sof, .i_eof, .i_sa_hit(lk[7]),
    .i_sa_index(lk[6:3]), .i_ctrl_pkt(lk[2]), .i_tag_class(lk[1:0]), .i_from_reserved(lk[8]),
    .i_vlan_tags(lk[10:9]), .o_act_valid, .o_flow_type, .o_dest_port, .o_drop_method, .o_drop_frame,
    .o_crc_corrupt, .o_pkt_error, .o_drop_internal, .o_association_active_flag, .o_protect_frame,
    .o_include_sci, .o_end_station_bit_enable, .o_scb_enable, .o_tag_bypass_size, .o_conf_offset,
    .o_conf_protect, .o_replay_protect, .o_validate_level, .o_ctx_valid, .o_ctx_index, .o_hdr_bypass,
    .o_hdr_size, .o_ctrl_pkt, .o_direction_ingress);
  mfa_frame_src #(.P_LEN(10)) u_src (.i_clk(i_core_clk), .i_rst, .i_go(go), .i_look(look), .o_sof(i_sof),
    .o_eof(i_eof), .o_look(lk));
  initial forever #5 i_core_clk = ~i_core_clk;
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : complete_run
  task automatic fail_out();
    n_fail++;
    complete_run();
  endtask : fail_out
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic [31:0] act(input logic [1:0] t, input logic [1:0] d, input logic [1:0] m,
                                      input logic [15:0] hi);
    return {8'h00, hi, m, 2'h0, d, t};
  endfunction : act
  task automatic edge_rdy();
    for (int k = 0; k < 20; k++) begin
      @(posedge i_core_clk);
      if (o_hreadyout === 1'b1) return;
    end
    fail_out();
  endtask : edge_rdy
  // address phase held until hready, then data phase held until hready
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] wd);
    @(posedge i_core_clk);
    i_hsel <= 1'b1;
    i_htrans <= HTRANS_NONSEQ;
    i_haddr <= {20'h0_0000, a};
    i_hwrite <= wr;
    edge_rdy();
    i_htrans <= 2'h0;
    i_hwdata <= wd;
    edge_rdy();
    rd = o_hrdata;
  endtask : bus
  task automatic frame_go(input logic [10:0] f);
    @(posedge i_core_clk);
    look <= f;
    go <= 1'b1;
    @(posedge i_core_clk);
    go <= 1'b0;
    for (int k = 0; k < 20 && o_act_valid !== 1'b1; k++) begin
      @(posedge i_core_clk);
      #1;
    end
    if (o_act_valid !== 1'b1) fail_out();
  endtask : frame_go
  task automatic frame_end();
    for (int k = 0; k < 20 && i_eof !== 1'b1; k++) begin
      @(posedge i_core_clk);
      #1;
    end
    if (i_eof !== 1'b1) fail_out();
    @(posedge i_core_clk);
    #1;
    chk(o_act_valid, 1'b0);
  endtask : frame_end
  ////////////////////////////////////////////////////////////////////////////
  task automatic s_regs();
    bus(0, IGR_BASE + 12'h03C, 32'h0000_0000);
    chk(rd, ACT_RESET);
    bus(1, EGR_BASE + 12'h014, 32'h00FF_7FCF);
    bus(1, 12'h400, 32'hFFFF_FFFF);
    bus(1, EGR_BASE + 12'h080, 32'hFFFF_FFFF);
    bus(0, EGR_BASE + 12'h014, 32'h0000_0000);
    chk(rd, 32'h00FF_7FCF);
    bus(0, 12'h400, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    bus(0, EGR_BASE, 32'h0000_0000);
    chk(rd, ACT_RESET);
    chk(o_hresp, 1'b0);
    chk(o_hreadyout, 1'b1);
  endtask : s_regs
  task automatic s_egress();
    logic e;
    for (int d = 0; d < 4; d++) begin
      e = d[0];
      bus(1, MISC_ADDR, 32'h0000_0000);
      bus(1, EGR_BASE + 12'h00C, act(FT_PROCESS, d[1:0], 2'h0, e ? 16'hD55F : 16'h2A20));
      frame_go({3'h0, 1'b1, 4'h3, 3'h1});
      chk({o_flow_type, o_dest_port}, {FT_PROCESS, d[1:0]});
      chk({o_protect_frame, o_include_sci, o_end_station_bit_enable, o_scb_enable}, {4{e}});
      chk({o_tag_bypass_size, o_conf_offset, o_conf_protect},
          e ? {2'h2, 7'h55, 1'b1} : {2'h1, 7'h2A, 1'b0});
      chk({o_association_active_flag, o_ctx_valid, o_ctx_index}, {e, 1'b1, 4'h3});
      frame_end();
    end
  endtask : s_egress
  task automatic s_drop();
    for (int m = 0; m < 5; m++) begin
      bus(1, EGR_BASE + 12'h01C, act(m == 4 ? FT_BYPASS : FT_DROP, 2'h3, m[1:0], 16'h0200));
      frame_go({3'h0, 1'b1, 4'h7, 3'h0});
      chk({o_flow_type, o_drop_method}, {m == 4 ? FT_BYPASS : FT_DROP, m[1:0]});
      chk({o_drop_frame, o_crc_corrupt, o_pkt_error, o_drop_internal, o_ctx_valid},
          {m < 4, m == 0, m == 1, m == 2, 1'b0});
      frame_end();
    end
  endtask : s_drop
  task automatic s_ingress();
    logic [1:0] v;
    logic dr;
    logic rs;
    for (int k = 0; k < 4; k++) begin
      v = (k == 3) ? 2'h0 : k[1:0];
      dr = (k >= 2);
      rs = (k == 2);
      bus(1, MISC_ADDR, 32'h0000_0002);
      bus(1, IGR_BASE + 12'h014, act(FT_PROCESS, PORT_CONTROLLED, DROP_PKTERR, {8'h33, 3'h0, v, 2'h3, dr}));
      frame_go({2'h2, rs, 1'b1, 4'h5, 3'h1});
      chk({o_direction_ingress, o_dest_port, o_drop_frame, o_pkt_error},
          {1'b1, PORT_CONTROLLED, k == 3, k == 3});
      if (k < 3) begin
        chk({o_flow_type, o_replay_protect, o_validate_level, o_conf_offset, o_tag_bypass_size},
            {FT_PROCESS, 1'b1, v, 7'h33, 2'h2});
      end
      frame_end();
    end
  endtask : s_ingress
  task automatic s_default();
    for (int n = 0; n < 8; n++) bus(1, NM_BASE + 12'(4 * n), act(n[0] ? FT_DROP : FT_BYPASS, n[2:1],
        DROP_INTERNAL, 16'h0200));
    for (int n = 0; n < 8; n++) begin
      frame_go({3'h0, 1'b0, 4'h0, n[2:0]});
      chk({o_flow_type, o_dest_port, o_drop_method},
          {n[0] ? FT_DROP : FT_BYPASS, n[2:1], DROP_INTERNAL});
      chk({o_drop_internal, o_association_active_flag, o_ctx_valid, o_ctrl_pkt},
          {n[0], 2'h0, n[2]});
      frame_end();
    end
    // a default flow set to process must fall back to drop
    bus(1, NM_BASE + 12'h014, act(FT_PROCESS, PORT_RESERVED, DROP_CRC, 16'h0000));
    frame_go({3'h0, 1'b0, 4'h0, 3'h5});
    chk({o_flow_type, o_drop_frame, o_crc_corrupt, o_ctx_valid}, {FT_DROP, 3'h6});
    frame_end();
  endtask : s_default
  task automatic s_hdr();
    logic [4:0] z[4] = '{5'h01, HDR_MIN, HDR_MAX, 5'h11};
    for (int j = 0; j < 4; j++) begin
      bus(1, MISC_ADDR, {19'h0_0000, z[j], 8'h00});
      frame_go({3'h0, 1'b0, 4'h0, 3'h0});
      chk(o_hdr_bypass, j == 1 || j == 2);
      chk(o_hdr_size, z[j]);
      frame_end();
    end
  endtask : s_hdr
  task automatic s_latch();
    bus(1, MISC_ADDR, 32'h0000_0000);
    bus(1, EGR_BASE + 12'h004, act(FT_BYPASS, PORT_COMMON, DROP_CRC, 16'h0000));
    frame_go({3'h0, 1'b1, 4'h1, 3'h1});
    bus(1, EGR_BASE + 12'h004, act(FT_DROP, PORT_UNCONTROLLED, DROP_PKTERR, 16'h0000));
    bus(0, STAT_ADDR, 32'h0000_0000);
    chk(rd[16], 1'b1);
    chk({o_flow_type, o_dest_port, o_drop_method, o_drop_frame},
        {FT_BYPASS, PORT_COMMON, DROP_CRC, 1'b0});
    frame_end();
    frame_go({3'h0, 1'b1, 4'h1, 3'h1});
    chk({o_flow_type, o_dest_port, o_drop_method}, {FT_DROP, PORT_UNCONTROLLED, DROP_PKTERR});
    frame_end();
  endtask : s_latch
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge i_core_clk);
    i_rst <= 1'b0;
    s_regs();
    s_egress();
    s_drop();
    s_ingress();
    s_default();
    s_hdr();
    s_latch();
    complete_run();
  end
endmodule : mfa_flow_action_bench
`default_nettype wire
